// file: pkg/nvm_pkg.sv
// Function
// - I/O addresses 0x00..0x3F decoded; data space sees them at plus 0x20.
// - Bit set, clear and test reach only I/O addresses 0x00..0x1F.
// - Bit set or clear rewrites the whole register from its read value.
// - Address is 9 bits, 0..511, split high/low; bits 15:9 read zero.
// - Address register is undefined after reset; software loads it first.
// - Data register holds write byte, and after a read the fetched byte.
// - Ready interrupt enabled and global enable give a level while not busy.
// - Master write enable set by software, cleared by hardware after four cycles.
// - Write strobe starts a write only while master write enable is set.
// - No write is started while the processor programs its flash.
// - A write lasts 8448 cycles of the 1 MHz oscillator, then strobe clears.
// - Starting a write stalls the processor for two cycles.
// - Read strobe fetches the byte at once and stalls four cycles.
// - During a write, reads are ignored and address changes are blocked.
// - A write in progress completes even across a plain reset; power-on reset aborts it.
// - In deep sleep a running write completes; oscillator keeps running.
package nvm_pkg;

  // ----------------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------------
  localparam logic [5:0]  IO_CTRL      = 6'h1c;
  localparam logic [5:0]  IO_DATA      = 6'h1d;
  localparam logic [5:0]  IO_ADDR_LO   = 6'h1e;
  localparam logic [5:0]  IO_ADDR_HI   = 6'h1f;
  localparam logic [15:0] DS_IO_FIRST  = 16'h0020;
  localparam logic [15:0] DS_IO_LAST   = 16'h005f;
  localparam int          RIE_BIT      = 3;
  localparam int          MWE_BIT      = 2;
  localparam int          WS_BIT       = 1;
  localparam int          RS_BIT       = 0;
  localparam logic [7:0]  DATA_RESET   = 8'h00;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int          MCLK_HZ      = 40000000;
  localparam int          OSC_HZ       = 1000000;
  localparam logic [5:0]  MCLK_PER_OSC = 6'(MCLK_HZ / OSC_HZ);
  localparam int          WRITE_OSC_CYCLES = 8448;
  localparam int          WRITE_TIME_US    = 8500;
  localparam logic [2:0]  MWE_HOLD_CYC = 3'h4;
  localparam logic [2:0]  WR_STALL_CYC = 3'h2;
  localparam logic [2:0]  RD_STALL_CYC = 3'h4;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        io_rd;
    logic        io_wr;
    logic [5:0]  io_addr;
    logic        ds_rd;
    logic        ds_wr;
    logic [15:0] ds_addr;
    logic        bit_set;
    logic        bit_clr;
    logic        bit_test;
    logic [4:0]  bit_addr;
    logic [2:0]  bit_sel;
    logic [7:0]  wdata;
  } cpu_req_s;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_BUSY = 2'b10
  } wr_state_e;

endpackage : nvm_pkg

// file: hw/nvm_cell_array.sv
`timescale 1ns/1ps
module nvm_cell_array
  import nvm_pkg::*;
(
  // Clock
  input  wire logic       mclk,
  // Write port
  input  wire logic       we,
  input  wire logic [8:0] waddr,
  input  wire logic [7:0] wdata,
  // Read port
  input  wire logic [8:0] raddr,
  output logic      [7:0] rdata_q
);

  logic [7:0] cells [0:511];

  always_ff @(posedge mclk) begin
    if (we) begin
      cells[waddr] <= wdata;
    end
    rdata_q <= cells[raddr];
  end

endmodule : nvm_cell_array

// file: hw/nvm_access_ctrl.sv
`timescale 1ns/1ps
module nvm_access_ctrl
  import nvm_pkg::*;
#(
  parameter int WRITE_OSC_CYC = WRITE_OSC_CYCLES
)(
  // Clock and resets
  input  wire logic     mclk,
  input  wire logic     rst,
  input  wire logic     por,
  // Processor access
  input  wire cpu_req_s cpu_req,
  input  wire logic     global_irq_en,
  input  wire logic     self_program_enable,
  // Answers
  output logic [7:0]    rdata_q,
  output logic          bit_value_q,
  output logic          stall_q,
  output logic          ready_irq_q,
  output logic          osc_run_q
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  logic [8:0]  nvm_address_q, nvm_address_d;
  logic [7:0]  nvm_data_q, nvm_data_d;
  logic        ready_irq_enable_q, ready_irq_enable_d;
  logic [2:0]  mwe_cnt_q, mwe_cnt_d;
  logic [2:0]  stall_cnt_q, stall_cnt_d;
  logic        rd_pend_q, rd_pend_d;
  logic [7:0]  rdata_d;
  logic        bit_value_d;
  wr_state_e   wr_state_q, wr_state_d;
  logic [8:0]  wr_addr_q, wr_addr_d;
  logic [7:0]  wr_data_q, wr_data_d;
  logic [13:0] osc_cnt_q, osc_cnt_d;
  logic [5:0]  pre_q, pre_d;
  logic        mem_we;
  logic [7:0]  mem_rdata_q;

  logic        busy;
  logic        mwe_on;
  logic        acc_rd;
  logic        acc_wr;
  logic [5:0]  acc_addr;
  logic [7:0]  acc_wdata;
  logic [7:0]  rv;
  logic [15:0] ds_off;
  logic        wr_go;
  logic        rd_go;
  logic        osc_tick;
  logic        wr_done;

  assign busy   = (wr_state_q == WR_BUSY);
  assign mwe_on = (mwe_cnt_q != 3'h0);

  // Reads of every mapped register; unmapped addresses answer zero.
  function automatic logic [7:0] io_read(input logic [5:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      IO_CTRL:    v = {4'h0, ready_irq_enable_q, mwe_on, busy, 1'b0};
      IO_DATA:    v = nvm_data_q;
      IO_ADDR_LO: v = nvm_address_q[7:0];
      IO_ADDR_HI: v = {7'h00, nvm_address_q[8]};
      default:    v = 8'h00;
    endcase
    return v;
  endfunction : io_read

  // --------------------------------------------------------------------
  // Access decode
  // --------------------------------------------------------------------
  always_comb begin
    acc_rd    = 1'b0;
    acc_wr    = 1'b0;
    acc_addr  = cpu_req.io_addr;
    acc_wdata = cpu_req.wdata;
    ds_off    = 16'(cpu_req.ds_addr - DS_IO_FIRST);
    if (cpu_req.io_rd || cpu_req.io_wr) begin
      acc_rd = cpu_req.io_rd;
      acc_wr = cpu_req.io_wr;
    end else if ((cpu_req.ds_rd || cpu_req.ds_wr) && cpu_req.ds_addr >= DS_IO_FIRST
                 && cpu_req.ds_addr <= DS_IO_LAST) begin
      acc_addr = ds_off[5:0];
      acc_rd   = cpu_req.ds_rd;
      acc_wr   = cpu_req.ds_wr;
    end else if (cpu_req.bit_set || cpu_req.bit_clr || cpu_req.bit_test) begin
      // The 5-bit operand reaches only the low half of the I/O space.
      acc_addr = {1'b0, cpu_req.bit_addr};
    end
    rv = io_read(acc_addr);
    if (!(cpu_req.io_rd || cpu_req.io_wr || cpu_req.ds_rd || cpu_req.ds_wr)
        && (cpu_req.bit_set || cpu_req.bit_clr)) begin
      // Whole register is written back, flags read as set included.
      acc_wr    = 1'b1;
      acc_wdata = rv;
      acc_wdata[cpu_req.bit_sel] = cpu_req.bit_set;
    end
  end

  // --------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------
  always_comb begin
    nvm_address_d      = nvm_address_q;
    nvm_data_d         = nvm_data_q;
    ready_irq_enable_d = ready_irq_enable_q;
    mwe_cnt_d          = mwe_on ? 3'(mwe_cnt_q - 3'h1) : 3'h0;
    stall_cnt_d        = (stall_cnt_q != 3'h0) ? 3'(stall_cnt_q - 3'h1) : 3'h0;
    rd_pend_d          = 1'b0;
    rdata_d            = rdata_q;
    bit_value_d        = bit_value_q;
    wr_go              = 1'b0;
    rd_go              = 1'b0;
    if (acc_rd) begin
      rdata_d = rv;
    end
    if (cpu_req.bit_test && !acc_rd && !acc_wr) begin
      bit_value_d = rv[cpu_req.bit_sel];
    end
    if (acc_wr) begin
      unique case (acc_addr)
        IO_ADDR_LO: if (!busy) nvm_address_d[7:0] = acc_wdata;
        IO_ADDR_HI: if (!busy) nvm_address_d[8] = acc_wdata[0];
        IO_DATA:    nvm_data_d = acc_wdata;
        IO_CTRL: begin
          ready_irq_enable_d = acc_wdata[RIE_BIT];
          // Rewriting a one while the window is open must not stretch it.
          if (acc_wdata[MWE_BIT] && !mwe_on) mwe_cnt_d = MWE_HOLD_CYC;
          wr_go = acc_wdata[WS_BIT] && mwe_on && !busy && !self_program_enable;
          rd_go = acc_wdata[RS_BIT] && !busy && !wr_go;
        end
        default: ;
      endcase
    end
    if (wr_go) stall_cnt_d = WR_STALL_CYC;
    if (rd_go) begin
      stall_cnt_d = RD_STALL_CYC;
      rd_pend_d   = 1'b1;
    end
    if (rd_pend_q) nvm_data_d = mem_rdata_q;
  end

  // Address is left alone by both resets and powers up undefined.
  always_ff @(posedge mclk) begin
    nvm_address_q <= nvm_address_d;
    if (rst || por) begin
      nvm_data_q         <= DATA_RESET;
      ready_irq_enable_q <= 1'b0;
      mwe_cnt_q          <= 3'h0;
      stall_cnt_q        <= 3'h0;
      stall_q            <= 1'b0;
      rd_pend_q          <= 1'b0;
      rdata_q            <= 8'h00;
      bit_value_q        <= 1'b0;
      ready_irq_q        <= 1'b0;
    end else begin
      nvm_data_q         <= nvm_data_d;
      ready_irq_enable_q <= ready_irq_enable_d;
      mwe_cnt_q          <= mwe_cnt_d;
      stall_cnt_q        <= stall_cnt_d;
      stall_q            <= (stall_cnt_d != 3'h0);
      rd_pend_q          <= rd_pend_d;
      rdata_q            <= rdata_d;
      bit_value_q        <= bit_value_d;
      ready_irq_q        <= ready_irq_enable_d && global_irq_en
                            && (wr_state_d == WR_IDLE);
    end
  end

  // --------------------------------------------------------------------
  // Self-timed write engine
  // --------------------------------------------------------------------
  assign osc_tick = (pre_q == 6'(MCLK_PER_OSC - 6'h1));
  assign wr_done  = busy && osc_tick && (osc_cnt_q == 14'(WRITE_OSC_CYC - 1));

  always_comb begin
    wr_state_d = wr_state_q;
    wr_addr_d  = wr_addr_q;
    wr_data_d  = wr_data_q;
    osc_cnt_d  = osc_cnt_q;
    pre_d      = osc_tick ? 6'h00 : 6'(pre_q + 6'h1);
    mem_we     = 1'b0;
    unique case (wr_state_q)
      WR_IDLE: begin
        pre_d     = 6'h00;
        osc_cnt_d = 14'h0000;
        if (wr_go) begin
          wr_state_d = WR_BUSY;
          wr_addr_d  = nvm_address_q;
          wr_data_d  = nvm_data_q;
        end
      end
      WR_BUSY: begin
        if (osc_tick) osc_cnt_d = 14'(osc_cnt_q + 14'h1);
        if (wr_done) begin
          mem_we     = 1'b1;
          wr_state_d = WR_IDLE;
        end
      end
    endcase
  end

  // A plain reset spares a write in flight so that it still completes.
  always_ff @(posedge mclk) begin
    if (por || (rst && !busy)) begin
      wr_state_q <= WR_IDLE;
      wr_addr_q  <= 9'h000;
      wr_data_q  <= 8'h00;
      osc_cnt_q  <= 14'h0000;
      pre_q      <= 6'h00;
      osc_run_q  <= 1'b0;
    end else begin
      wr_state_q <= wr_state_d;
      wr_addr_q  <= wr_addr_d;
      wr_data_q  <= wr_data_d;
      osc_cnt_q  <= osc_cnt_d;
      pre_q      <= pre_d;
      // Sleep logic must keep the oscillator up while this is high.
      osc_run_q  <= (wr_state_d == WR_BUSY);
    end
  end

  nvm_cell_array u_cells (
    .mclk    (mclk),
    .we      (mem_we),
    .waddr   (wr_addr_q),
    .wdata   (wr_data_q),
    .raddr   (nvm_address_q),
    .rdata_q (mem_rdata_q)
  );

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  sequence mwe_window_s;
    mwe_on [*4] ##1 !mwe_on;
  endsequence

  sequence wr_stall_s;
    stall_q [*2] ##1 !stall_q;
  endsequence

  sequence rd_stall_s;
    stall_q [*4] ##1 !stall_q;
  endsequence

  chk_mwe_timeout: assert property (
    @(posedge mclk) disable iff (rst || por) $rose(mwe_on) |-> mwe_window_s)
    else $error("master write enable did not time out after four cycles");

  chk_write_needs_mwe: assert property (
    @(posedge mclk) disable iff (rst || por) $rose(busy) |-> $past(mwe_on))
    else $error("write started without master write enable");

  chk_write_stall: assert property (
    @(posedge mclk) disable iff (rst || por) $rose(busy) |-> wr_stall_s)
    else $error("write start did not stall two cycles");

  chk_read_stall: assert property (
    @(posedge mclk) disable iff (rst || por) rd_go |=> rd_stall_s)
    else $error("read did not stall four cycles");

  chk_read_data: assert property (
    @(posedge mclk) disable iff (rst || por)
    rd_go ##1 1'b1 |=> nvm_data_q == $past(mem_rdata_q))
    else $error("data register missed the fetched byte");

  chk_read_blocked: assert property (
    @(posedge mclk) disable iff (rst || por)
    busy |-> !rd_go && !$changed(nvm_address_q))
    else $error("read or address change during a write");

  chk_flash_block: assert property (
    @(posedge mclk) disable iff (rst || por) self_program_enable |-> !wr_go)
    else $error("write started during flash programming");

  chk_irq_level: assert property (
    @(posedge mclk) disable iff (rst || por)
    busy |-> ##1 (!ready_irq_q || !busy))
    else $error("ready interrupt asserted during a write");

  chk_write_length: assert property (
    @(posedge mclk) disable iff (por)
    $fell(busy) |-> $past(osc_cnt_q) == 14'(WRITE_OSC_CYC - 1) && $past(osc_tick))
    else $error("write did not last the programmed oscillator count");

  chk_reset_spares: assert property (
    @(posedge mclk) disable iff (por) (rst && busy && !wr_done) |=> busy)
    else $error("reset aborted a write in progress");

  // Read strobe and reserved bits must never leak into a control read.
  chk_ctrl_read_zero: assert property (
    @(posedge mclk) disable iff (rst || por)
    acc_rd && (acc_addr == IO_CTRL) |=> (rdata_q[RS_BIT] == 1'b0) && (rdata_q[7:4] == 4'h0))
    else $error("control read showed the read strobe or a reserved bit");

  chk_addr_high_zero: assert property (
    @(posedge mclk) disable iff (rst || por)
    acc_rd && (acc_addr == IO_ADDR_HI) |=> (rdata_q[7:1] == 7'h00))
    else $error("address high read showed a reserved bit");

  chk_osc_kept: assert property (
    @(posedge mclk) disable iff (por)
    busy |-> osc_run_q)
    else $error("oscillator request dropped during a write");

endmodule : nvm_access_ctrl

// file: tb/tb_nvm_access_ctrl.sv
`timescale 1ns/1ps
module tb_nvm_access_ctrl
  import nvm_pkg::*;
;
  // ----------------------------------------------------------------------
  // Bench setup
  // ----------------------------------------------------------------------
  // A short write keeps the run small; timing expectations follow from it.
  localparam int OSC    = 3;
  localparam int WR_MCLK = OSC * 40;
  localparam int RD = 0, WR = 1, DR = 2, DW = 3, BS = 4, BC = 5, BT = 6;

  logic       mclk = 1'b0;
  logic       rst  = 1'b1;
  logic       por  = 1'b1;
  logic       gie  = 1'b0;
  logic       spe  = 1'b0;
  cpu_req_s   req  = '0;
  logic [7:0] rdata_q;
  logic       bit_value_q;
  logic       stall_q;
  logic       ready_irq_q;
  logic       osc_run_q;
  int         n_mismatch  = 0;
  int         check_count = 0;
  int         cyc         = 0;
  int         t0;

  always #12.5 mclk = ~mclk;

  nvm_access_ctrl #(.WRITE_OSC_CYC(OSC)) u_dut (
    .mclk(mclk), .rst(rst), .por(por), .cpu_req(req), .global_irq_en(gie),
    .self_program_enable(spe), .rdata_q(rdata_q), .bit_value_q(bit_value_q),
    .stall_q(stall_q), .ready_irq_q(ready_irq_q), .osc_run_q(osc_run_q));

  // ----------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic cpu_req_s mk(int k, logic [15:0] a, logic [7:0] d);
    cpu_req_s r;
    r = '0;
    {r.io_rd, r.io_wr, r.ds_rd, r.ds_wr, r.bit_set, r.bit_clr, r.bit_test} = 7'h40 >> k;
    r.io_addr  = a[5:0];
    r.ds_addr  = a;
    r.bit_addr = a[4:0];
    r.bit_sel  = d[2:0];
    r.wdata    = d;
    return r;
  endfunction : mk

  // Each call drives the whole request once, just after an edge.
  task automatic op(cpu_req_s r);
    req = r;
    @(posedge mclk);
    #1;
  endtask : op

  task automatic idle(int n);
    repeat (n) op('0);
  endtask : idle

  task automatic rd(logic [5:0] a, logic [7:0] exp, string what);
    op(mk(RD, 16'(a), 8'h00));
    check(what, rdata_q, exp);
  endtask : rd

  task automatic stall_len(logic [2:0] exp, string what);
    int k;
    k = 0;
    while (stall_q === 1'b1 && k < 8) begin
      op('0);
      k++;
    end
    check(what, 8'(k), 8'(exp));
  endtask : stall_len

  task automatic wait_idle();
    int k;
    k = 0;
    while (osc_run_q === 1'b1 && k < 400) begin
      op('0);
      k++;
    end
    if (k == 400) begin
      n_mismatch++;
    end
  endtask : wait_idle

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      results();
    end
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    #1;
    idle(8);
    rst = 1'b0;
    por = 1'b0;
    gie = 1'b1;
    rd(IO_CTRL, 8'h00, "ctrl_reset");
    rd(IO_DATA, DATA_RESET, "data_reset");
    op(mk(WR, 16'(IO_ADDR_HI), 8'h01));
    op(mk(WR, 16'(IO_ADDR_LO), 8'h5a));
    rd(IO_ADDR_HI, 8'h01, "addr_hi");
    rd(IO_ADDR_LO, 8'h5a, "addr_lo");
    op(mk(DW, DS_IO_FIRST + 16'(IO_DATA), 8'h3c));
    rd(IO_DATA, 8'h3c, "ds_write");
    op(mk(DR, DS_IO_FIRST + 16'(IO_DATA), 8'h00));
    check("ds_read", rdata_q, 8'h3c);
    op(mk(DR, DS_IO_LAST + 16'h0001, 8'h00));
    check("ds_unmapped", rdata_q, 8'h3c);
    // The enable must lapse on its own before a late strobe arrives.
    op(mk(WR, 16'(IO_CTRL), 8'h04));
    rd(IO_CTRL, 8'h04, "mwe_open");
    idle(6);
    rd(IO_CTRL, 8'h00, "mwe_closed");
    op(mk(WR, 16'(IO_CTRL), 8'h02));
    check("late_strobe", 8'(osc_run_q), 8'h00);
    spe = 1'b1;
    op(mk(WR, 16'(IO_CTRL), 8'h04));
    op(mk(WR, 16'(IO_CTRL), 8'h02));
    check("flash_busy", 8'(osc_run_q), 8'h00);
    rd(IO_CTRL, 8'h04, "flash_busy_ctrl");
    spe = 1'b0;
    op(mk(WR, 16'(IO_DATA), 8'h5c));
    // Let the enable opened above lapse, so that a fresh window starts.
    idle(2);
    gie = 1'b0;
    op(mk(WR, 16'(IO_CTRL), 8'h04));
    op(mk(WR, 16'(IO_CTRL), 8'h02));
    gie = 1'b1;
    t0 = cyc;
    check("write_run", 8'(osc_run_q), 8'h01);
    stall_len(WR_STALL_CYC, "write_stall");
    rd(IO_CTRL, 8'h06, "busy_ctrl");
    op(mk(WR, 16'(IO_ADDR_LO), 8'h00));
    rd(IO_ADDR_LO, 8'h5a, "addr_locked");
    op(mk(BS, 16'(IO_CTRL), 8'h03));
    op(mk(BS, 16'(IO_CTRL), 8'h00));
    check("busy_read_stall", 8'(stall_q), 8'h00);
    idle(2);
    check("irq_busy", 8'(ready_irq_q), 8'h00);
    wait_idle();
    check("write_time", 8'((cyc - t0) >= WR_MCLK - 39 && (cyc - t0) <= WR_MCLK + 2), 8'h01);
    rd(IO_CTRL, 8'h08, "write_done");
    check("irq_ready", 8'(ready_irq_q), 8'h01);
    op(mk(BT, 16'(IO_CTRL), 8'h03));
    check("bit_test", 8'(bit_value_q), 8'h01);
    op(mk(BC, 16'(IO_CTRL), 8'h03));
    idle(2);
    check("irq_off", 8'(ready_irq_q), 8'h00);
    op(mk(WR, 16'(IO_DATA), 8'h00));
    op(mk(WR, 16'(IO_CTRL), 8'h01));
    stall_len(RD_STALL_CYC, "read_stall");
    rd(IO_DATA, 8'h5c, "readback");
    rd(IO_CTRL, 8'h00, "read_clear");
    // A reset in mid-write must not cut the write short.
    op(mk(WR, 16'(IO_DATA), 8'h77));
    op(mk(WR, 16'(IO_CTRL), 8'h04));
    op(mk(WR, 16'(IO_CTRL), 8'h02));
    rst = 1'b1;
    idle(1);
    rst = 1'b0;
    check("rst_spares", 8'(osc_run_q), 8'h01);
    wait_idle();
    op(mk(WR, 16'(IO_CTRL), 8'h01));
    stall_len(RD_STALL_CYC, "read_stall2");
    rd(IO_DATA, 8'h77, "rst_write_done");
    results();
  end

endmodule : tb_nvm_access_ctrl
